// File: rtl/printer_engine_defines.vh
// printer_engine_defines.vh: offsets, field positions, reset values, timing counts
// assumes: included by the print engine design files; clock is 125 MHz
`ifndef PRINTER_ENGINE_DEFINES_VH
`define PRINTER_ENGINE_DEFINES_VH

// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define CLK_MHZ           125
`define CARR_STEP_NS      2080000
`define SLOW_STEP_NS      4160000
`define SOL_PULSE_NS      400000
`define NS_TO_CYC(ns)     (((ns) * `CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL          12'h000
`define OFF_STATUS        12'h004
`define OFF_IRQ_STAT      12'h008
`define OFF_IRQ_MASK      12'h00C
`define OFF_RX_DATA       12'h010
`define OFF_HEAD          12'h014
`define OFF_CARR_CMD      12'h018
`define OFF_FEED_CMD      12'h01C
`define OFF_LEVEL         12'h020

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_MODE_BIT     0
`define CTRL_COND_BIT     1
`define CTRL_HOME_BIT     2

// ----------------------------------------------------------------
// command fields (carriage and feed step command)
// ----------------------------------------------------------------
`define CMD_DIR_BIT       16
`define CMD_CNT_W         16

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define IRQ_RX_BIT        0
`define IRQ_CARR_BIT      1
`define IRQ_FEED_BIT      2
`define IRQ_HOME_BIT      3
`define IRQ_PAPER_BIT     4
`define IRQ_PFAIL_BIT     5
`define IRQ_OVF_BIT       6
`define IRQ_W             7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PHASE_RST         4'h3
`define CTRL_RST          3'h0

`endif

// File: rtl/rx_store.v
// rx_store.v: byte store for received host characters
// assumes: single clock, one write port and one read port, registered read data
`timescale 1ns/1ps

module rx_store #(
  parameter AW = 8,                       // address width
  parameter DW = 8                        // data width
) (
  input  wire          pclk,              // clock
  input  wire          we,                // write enable
  input  wire [AW-1:0] waddr,             // write address
  input  wire [DW-1:0] wdata,             // write data
  input  wire [AW-1:0] raddr,             // read address
  output reg  [DW-1:0] rdata              // registered read data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];         // storage array

  // ----------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // rx_store

// File: rtl/stepper_seq.v
// stepper_seq.v: two-phase-on sequencer for one four-phase stepper
// assumes: pclk domain; start is a one-cycle pulse taken only while idle
`timescale 1ns/1ps
`include "printer_engine_defines.vh"

module stepper_seq #(
  parameter CW = 20                       // step timer width
) (
  input  wire          pclk,              // clock
  input  wire          presetn,           // async reset, active low
  input  wire          halt,              // force idle (power fail)
  input  wire          start,             // begin a move
  input  wire          dir,               // 1: reverse order
  input  wire [15:0]   steps,             // steps to make
  input  wire [CW-1:0] period,            // cycles per step
  output reg  [3:0]    phase_r,           // phases a..d
  output reg           busy_r,            // moving
  output reg           done_r             // one-cycle pulse at end of move
);

  reg [CW-1:0] tmr_r;                     // step timer
  reg [15:0]   left_r;                    // steps remaining

  // rotate adjacent pair one position
  function [3:0] rot;
    input [3:0] p;
    input       d;
    begin
      rot = d ? {p[0], p[3:1]} : {p[2:0], p[3]};
    end
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= `PHASE_RST;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      tmr_r   <= {CW{1'b0}};
      left_r  <= 16'h0000;
    end else begin
      done_r <= 1'b0;
      if (halt) begin
        busy_r <= 1'b0;
      end else if (!busy_r) begin
        if (start && steps != 16'h0000) begin
          busy_r  <= 1'b1;
          left_r  <= steps;
          tmr_r   <= period;
          phase_r <= rot(phase_r, dir);
        end
      end else if (tmr_r > {{(CW-1){1'b0}}, 1'b1}) begin
        tmr_r <= tmr_r - {{(CW-1){1'b0}}, 1'b1};
      end else if (left_r == 16'h0001) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end else begin
        left_r  <= left_r - 16'h0001;
        tmr_r   <= period;
        phase_r <= rot(phase_r, dir);
      end
    end
  end

endmodule // stepper_seq

// File: rtl/printer_engine_controller.v
// printer_engine_controller.v: host byte port, print head and stepper control
// assumes: APB slave on pclk; mechanism and host pins are asynchronous
//
// Operation
// - drive solenoids, phases, current limit outputs
// - host port needs strobed mode before accepting
// - host strobes once per character on bit2
// - eight data bits taken from host port
// - capture data on strobe trailing edge
// - ready output on bit1 after capture
// - characters kept in 256-byte store
// - nine solenoids on port plus bit4
// - steppers energise two adjacent phases always (phase outputs are all off while in reset)
// - carriage step 2.08 ms for normal
// - carriage step 4.16 ms when condensed
// - feed step always 4.16 ms
// - idle motor asserts its current limit
// - power fail resets, solenoids held off
// - solenoid pulse about 0.4 ms
// - home carriage at reset or init
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "printer_engine_defines.vh"

module printer_engine_controller #(
  parameter CARR_CYC = `NS_TO_CYC(`CARR_STEP_NS),  // normal carriage step
  parameter SLOW_CYC = `NS_TO_CYC(`SLOW_STEP_NS),  // condensed / feed step
  parameter SOL_CYC  = `NS_TO_CYC(`SOL_PULSE_NS),  // solenoid pulse
  parameter HOME_MAX = 16'h0400                    // homing step limit
) (
  input  wire        pclk,                // clock
  input  wire        presetn,             // async reset, active low
  input  wire        psel,                // apb select
  input  wire        penable,             // apb enable
  input  wire        pwrite,              // apb write
  input  wire [11:0] paddr,               // apb address
  input  wire [31:0] pwdata,              // apb write data
  output reg  [31:0] prdata,              // apb read data
  output reg         pready,              // apb ready
  output reg         pslverr,             // apb error
  input  wire [7:0]  host_data_port,      // host character
  input  wire        portc_bit2,          // host strobe, active low pulse
  output reg         portc_bit1,          // ready handshake
  output reg  [7:0]  solenoid_port,       // solenoids 1..8
  output reg         portc_bit4,          // solenoid 9
  output reg         carriage_phase_a,    // carriage phase a
  output reg         carriage_phase_b,    // carriage phase b
  output reg         carriage_phase_c,    // carriage phase c
  output reg         carriage_phase_d,    // carriage phase d
  output reg         feed_phase_a,        // feed phase a
  output reg         feed_phase_b,        // feed phase b
  output reg         feed_phase_c,        // feed phase c
  output reg         feed_phase_d,        // feed phase d
  output reg         carriage_current_limit, // carriage idle reduction
  output reg         feed_current_limit,  // feed idle reduction
  input  wire        head_timing_pulse,   // head position timing
  input  wire        home_position_sense, // high at left end
  input  wire        paper_out_sense,     // high when paper absent
  input  wire        power_fail_sense,    // high while 24 V rail is low
  output reg         irq                  // level interrupt
);

  localparam CW = 20;                     // step timer width
  localparam SW = 16;                     // solenoid timer width

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [5:0] s1_r;                         // first stage
  reg [5:0] s2_r;                         // second stage
  reg [5:0] s3_r;                         // delayed for edges
  reg [7:0] d1_r;                         // data first stage
  reg [7:0] d2_r;                         // data second stage

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 6'h01;
      s2_r <= 6'h01;
      s3_r <= 6'h01;
      d1_r <= 8'h00;
      d2_r <= 8'h00;
    end else begin
      s1_r <= {power_fail_sense, paper_out_sense, home_position_sense,
               head_timing_pulse, 1'b0, portc_bit2};
      s2_r <= s1_r;
      s3_r <= s2_r;
      d1_r <= host_data_port;
      d2_r <= d1_r;
    end
  end

  wire stb_rise   = s2_r[0] & ~s3_r[0];   // strobe trailing edge
  wire tim_rise   = s2_r[2] & ~s3_r[2];   // timing pulse edge
  wire home_now   = s2_r[3];              // at left end
  wire paper_out  = s2_r[4];              // no paper
  wire pfail      = s2_r[5];              // supply low

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [2:0]          ctrl_r;             // mode, condensed, home request
  reg  [`IRQ_W-1:0]   ist_r;              // sticky events
  reg  [`IRQ_W-1:0]   imask_r;            // enable mask
  reg  [8:0]          head_r;             // dots to fire
  reg                 head_go_r;          // fire request
  reg  [7:0]          wp_r;               // store write pointer
  reg  [7:0]          rp_r;               // store read pointer
  reg  [8:0]          lvl_r;              // characters held
  reg  [SW-1:0]       sol_t_r;            // solenoid timer
  reg                 home_busy_r;        // homing in progress
  reg                 c_start_r;          // carriage start pulse
  reg                 c_dir_r;            // carriage direction
  reg  [15:0]         c_steps_r;          // carriage steps
  reg                 f_start_r;          // feed start pulse
  reg  [15:0]         f_steps_r;          // feed steps
  wire [7:0]          rd_byte;            // store read data
  wire [3:0]          c_ph;               // carriage phases
  wire [3:0]          f_ph;               // feed phases
  wire                c_busy;             // carriage moving
  wire                c_done;             // carriage move finished
  wire                f_busy;             // feed moving
  wire                f_done;             // feed move finished

  wire acc    = psel & penable;           // access phase
  wire wr     = acc & pwrite;             // write strobe
  wire rd     = acc & ~pwrite;            // read strobe
  wire mode   = ctrl_r[`CTRL_MODE_BIT];
  wire full   = lvl_r[8];
  wire take   = stb_rise & mode & ~pfail;
  wire store  = take & ~full;             // byte written into store
  wire pop    = rd & (paddr == `OFF_RX_DATA) & (lvl_r != 9'h000);

  // decode of a known offset
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OFF_CTRL) || (a == `OFF_STATUS) || (a == `OFF_IRQ_STAT) ||
               (a == `OFF_IRQ_MASK) || (a == `OFF_RX_DATA) || (a == `OFF_HEAD) ||
               (a == `OFF_CARR_CMD) || (a == `OFF_FEED_CMD) || (a == `OFF_LEVEL);
    end
  endfunction

  // ----------------------------------------------------------------
  // character store
  // ----------------------------------------------------------------
  rx_store #(.AW(8), .DW(8)) u_store (
    .pclk  (pclk),
    .we    (store),
    .waddr (wp_r),
    .wdata (d2_r),
    .raddr (rp_r),
    .rdata (rd_byte)
  );

  // ----------------------------------------------------------------
  // stepper sequencers
  // ----------------------------------------------------------------
  wire [CW-1:0] c_per = ctrl_r[`CTRL_COND_BIT] ? SLOW_CYC[CW-1:0]
                                               : CARR_CYC[CW-1:0];
  // homing stops the carriage as soon as the left end is seen, no overshoot
  wire          c_halt = pfail | (home_busy_r & home_now);

  stepper_seq #(.CW(CW)) u_carr (
    .pclk    (pclk),
    .presetn (presetn),
    .halt    (c_halt),
    .start   (c_start_r),
    .dir     (c_dir_r),
    .steps   (c_steps_r),
    .period  (c_per),
    .phase_r (c_ph),
    .busy_r  (c_busy),
    .done_r  (c_done)
  );

  stepper_seq #(.CW(CW)) u_feed (
    .pclk    (pclk),
    .presetn (presetn),
    .halt    (pfail),
    .start   (f_start_r),
    .dir     (1'b0),
    .steps   (f_steps_r),
    .period  (SLOW_CYC[CW-1:0]),
    .phase_r (f_ph),
    .busy_r  (f_busy),
    .done_r  (f_done)
  );

  // ----------------------------------------------------------------
  // control, host port, head and homing
  // ----------------------------------------------------------------
  wire [`IRQ_W-1:0] ev = {take & full, pfail, tim_rise & paper_out,
                          home_busy_r & home_now, f_done, c_done, store};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= `CTRL_RST;
      ist_r       <= {`IRQ_W{1'b0}};
      imask_r     <= {`IRQ_W{1'b0}};
      head_r      <= 9'h000;
      head_go_r   <= 1'b0;
      wp_r        <= 8'h00;
      rp_r        <= 8'h00;
      lvl_r       <= 9'h000;
      home_busy_r <= 1'b1;                // home after power-on
      c_start_r   <= 1'b0;
      c_dir_r     <= 1'b0;
      c_steps_r   <= 16'h0000;
      f_start_r   <= 1'b0;
      f_steps_r   <= 16'h0000;
      portc_bit1  <= 1'b0;
    end else if (pfail) begin
      // supply low: control, store, ready and homing back to initial state; mask kept, events still set
      ctrl_r      <= `CTRL_RST;
      ist_r       <= ist_r | ev;
      head_go_r   <= 1'b0;
      wp_r        <= 8'h00;
      rp_r        <= 8'h00;
      lvl_r       <= 9'h000;
      home_busy_r <= 1'b1;
      c_start_r   <= 1'b0;
      f_start_r   <= 1'b0;
      portc_bit1  <= 1'b0;
    end else begin
      c_start_r <= 1'b0;
      f_start_r <= 1'b0;
      head_go_r <= 1'b0;
      // sticky events, set wins over write-one clear
      ist_r <= (wr && paddr == `OFF_IRQ_STAT) ? ((ist_r & ~pwdata[`IRQ_W-1:0]) | ev)
                                              : (ist_r | ev);
      // ready: raised on capture, dropped at next strobe edge
      if (take) begin
        portc_bit1 <= 1'b1;
      end else if (s2_r[0] == 1'b0) begin
        portc_bit1 <= 1'b0;
      end
      if (store) begin
        wp_r <= wp_r + 8'h01;
      end
      if (pop) begin
        rp_r <= rp_r + 8'h01;
      end
      if (store && !pop) begin
        lvl_r <= lvl_r + 9'h001;
      end else if (pop && !store) begin
        lvl_r <= lvl_r - 9'h001;
      end
      // homing: step left until home seen
      if (home_busy_r) begin
        if (home_now) begin
          home_busy_r <= 1'b0;
        end else if (!c_busy && !c_start_r) begin
          c_dir_r   <= 1'b1;
          c_steps_r <= HOME_MAX[15:0];
          c_start_r <= 1'b1;
        end
      end
      if (wr) begin
        case (paddr)
          `OFF_CTRL: begin
            ctrl_r <= pwdata[2:0];
            if (pwdata[`CTRL_HOME_BIT]) begin
              home_busy_r <= 1'b1;
            end
          end
          `OFF_IRQ_MASK: begin
            imask_r <= pwdata[`IRQ_W-1:0];
          end
          `OFF_HEAD: begin
            head_r    <= pwdata[8:0];
            head_go_r <= 1'b1;
          end
          `OFF_CARR_CMD: begin
            if (!home_busy_r && !c_busy) begin
              c_dir_r   <= pwdata[`CMD_DIR_BIT];
              c_steps_r <= pwdata[`CMD_CNT_W-1:0];
              c_start_r <= 1'b1;
            end
          end
          `OFF_FEED_CMD: begin
            if (!f_busy) begin
              f_steps_r <= pwdata[`CMD_CNT_W-1:0];
              f_start_r <= 1'b1;
            end
          end
          default: begin
            ctrl_r <= ctrl_r;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // solenoid pulse timer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sol_t_r       <= {SW{1'b0}};
      solenoid_port <= 8'h00;
      portc_bit4    <= 1'b0;
    end else if (pfail) begin
      sol_t_r       <= {SW{1'b0}};
      solenoid_port <= 8'h00;
      portc_bit4    <= 1'b0;
    end else if (head_go_r) begin
      sol_t_r       <= SOL_CYC[SW-1:0];
      solenoid_port <= head_r[7:0];
      portc_bit4    <= head_r[8];
    end else if (sol_t_r > {{(SW-1){1'b0}}, 1'b1}) begin
      sol_t_r <= sol_t_r - {{(SW-1){1'b0}}, 1'b1};
    end else begin
      sol_t_r       <= {SW{1'b0}};
      solenoid_port <= 8'h00;
      portc_bit4    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // motor outputs, apb answer, interrupt
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {carriage_phase_d, carriage_phase_c, carriage_phase_b, carriage_phase_a} <= 4'h0;
      {feed_phase_d, feed_phase_c, feed_phase_b, feed_phase_a} <= 4'h0;
      carriage_current_limit <= 1'b1;
      feed_current_limit     <= 1'b1;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      {carriage_phase_d, carriage_phase_c, carriage_phase_b, carriage_phase_a} <= c_ph;
      {feed_phase_d, feed_phase_c, feed_phase_b, feed_phase_a} <= f_ph;
      carriage_current_limit <= ~c_busy;
      feed_current_limit     <= ~f_busy;
      irq     <= |(ist_r & imask_r);
      pready  <= psel & ~pready;          // ready in first access cycle, no wait state
      pslverr <= psel & ~pready & ~mapped(paddr);
      if (psel && !pwrite) begin
        case (paddr)
          `OFF_CTRL:     prdata <= {29'h0, ctrl_r};
          `OFF_STATUS:   prdata <= {24'h0, pfail, paper_out, home_now, home_busy_r,
                                    f_busy, c_busy, full, portc_bit1};
          `OFF_IRQ_STAT: prdata <= {25'h0, ist_r};
          `OFF_IRQ_MASK: prdata <= {25'h0, imask_r};
          `OFF_RX_DATA:  prdata <= {24'h0, rd_byte};
          `OFF_HEAD:     prdata <= {23'h0, head_r};
          `OFF_LEVEL:    prdata <= {23'h0, lvl_r};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // printer_engine_controller

// File: verification/pec_props.sv
// checker for the print engine controller, ports only
// assumes: bound into the top module, single clock pclk
`timescale 1ns/1ps
module pec_props #(
  parameter CARR_CYC = 20,
  parameter SLOW_CYC = 40,
  parameter SOL_CYC  = 10,
  parameter HOME_MAX = 16'h0400
) (
  input wire       pclk,
  input wire       presetn,
  input wire       portc_bit2,
  input wire       portc_bit1,
  input wire [7:0] solenoid_port,
  input wire       portc_bit4,
  input wire       carriage_phase_a,
  input wire       carriage_phase_b,
  input wire       carriage_phase_c,
  input wire       carriage_phase_d,
  input wire       feed_phase_a,
  input wire       feed_phase_b,
  input wire       feed_phase_c,
  input wire       feed_phase_d,
  input wire       carriage_current_limit,
  input wire       feed_current_limit,
  input wire       power_fail_sense
);
  wire [3:0] cp = {carriage_phase_d, carriage_phase_c, carriage_phase_b, carriage_phase_a};
  wire [3:0] fp = {feed_phase_d, feed_phase_c, feed_phase_b, feed_phase_a};
  wire       sol = |{portc_bit4, solenoid_port};  // any solenoid on
  reg [19:0] sol_n;                               // cycles the head is on
  reg [19:0] cg_n;                                // cycles since carriage step
  reg [19:0] fg_n;                                // cycles since feed step
  // gap counters reset to all ones and saturate, so the first step after reset is not judged;
  // leaving the all-off reset pattern is not a step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sol_n <= 20'h00000;
      cg_n  <= 20'hFFFFF;
      fg_n  <= 20'hFFFFF;
    end else begin
      sol_n <= sol ? sol_n + 20'h00001 : 20'h00000;
      cg_n  <= (!$stable(cp) && |$past(cp)) ? 20'h00000 : (&cg_n ? cg_n : cg_n + 20'h00001);
      fg_n  <= (!$stable(fp) && |$past(fp)) ? 20'h00000 : (&fg_n ? fg_n : fg_n + 20'h00001);
    end
  end
  function automatic bit pair_ok(input [3:0] p);
    return p inside {4'h0, 4'h3, 4'h6, 4'hC, 4'h9};
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_carr_pair: assert property (pair_ok(cp)) else $error("carriage phase pattern bad");
  a_feed_pair: assert property (pair_ok(fp)) else $error("feed phase pattern bad");
  a_carr_idle: assert property (!$stable(cp) && |$past(cp) |-> !carriage_current_limit)
    else $error("carr limit");
  a_feed_idle: assert property (!$stable(fp) && |$past(fp) |-> !feed_current_limit)
    else $error("feed limit");
  a_carr_gap: assert property (!$stable(cp) && !(&cg_n) |-> cg_n >= CARR_CYC - 1)
    else $error("c gap");
  a_feed_gap: assert property (!$stable(fp) && !(&fg_n) |-> fg_n >= SLOW_CYC - 1)
    else $error("f gap");
  a_sol_len: assert property ($fell(sol) |-> sol_n == SOL_CYC)
    else $error("solenoid pulse length");
  a_pfail_quiet: assert property (power_fail_sense [*4] |-> !sol)
    else $error("head on in pfail");
  a_ready_late: assert property ($rose(portc_bit1) |-> $past(portc_bit2, 2))
    else $error("early rdy");
  a_ready_drop: assert property (!portc_bit2 [*5] |-> !portc_bit1)
    else $error("ready held");
  c_step: cover property (!$stable(cp));
  c_head: cover property ($fell(sol));
  c_ready: cover property ($rose(portc_bit1));
endmodule // pec_props
bind printer_engine_controller pec_props #(.CARR_CYC(CARR_CYC), .SLOW_CYC(SLOW_CYC),
  .SOL_CYC(SOL_CYC), .HOME_MAX(HOME_MAX)) props_u (.*);

// File: verification/print_mech_model.sv
// print mechanism model: carriage position, home, timing and paper sensors
// assumes: one carriage step per change of the controller's phase pair
`timescale 1ns/1ps
module print_mech_model (
  input  wire pclk,
  input  wire ca,
  input  wire cb,
  input  wire cc,
  input  wire cd,
  input  wire paper_gone,
  output reg  home_position_sense = 1'b0,
  output reg  head_timing_pulse = 1'b0,
  output wire paper_out_sense
);
  reg [3:0]  last_r = 4'h0;     // previous phase pair
  integer    pos = 3;           // carriage starts right of home
  wire [3:0] now = {cd, cc, cb, ca};
  assign paper_out_sense = paper_gone;
  // rotate left moves right, rotate right moves toward home
  always @(posedge pclk) begin
    if (now != last_r && last_r != 4'h0)
      pos <= ({last_r[2:0], last_r[3]} == now) ? pos + 1 : pos - 1;
    last_r <= now;
    home_position_sense <= (pos <= 0);
    head_timing_pulse <= pos[0];
  end
endmodule // print_mech_model

// File: verification/printer_engine_controller_tb.sv
// bench for the print engine controller: apb, host strobe, motors, head
// assumes: mechanism model on the sensor pins, 125 MHz pclk
`timescale 1ns/1ps
`include "printer_engine_defines.vh"
module printer_engine_controller_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, q;
  reg [7:0] host_data_port = 0;
  reg portc_bit2 = 1, power_fail_sense = 0, paper_gone = 0, use_feed = 0, err;
  wire [31:0] prdata;
  wire pready, pslverr, portc_bit1, portc_bit4, irq, cl, fl, hts, hps, pos_n;
  wire [7:0] sol;
  wire [3:0] cph, fph;
  wire [3:0] mph = use_feed ? fph : cph;
  integer fails = 0, checks_done = 0, n;
  reg [3:0] p0, p1;
  printer_engine_controller #(.CARR_CYC(20), .SLOW_CYC(40), .SOL_CYC(10), .HOME_MAX(8))
    dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_data_port(host_data_port), .portc_bit2(portc_bit2), .portc_bit1(portc_bit1),
    .solenoid_port(sol), .portc_bit4(portc_bit4), .carriage_phase_a(cph[0]),
    .carriage_phase_b(cph[1]), .carriage_phase_c(cph[2]), .carriage_phase_d(cph[3]),
    .feed_phase_a(fph[0]), .feed_phase_b(fph[1]), .feed_phase_c(fph[2]),
    .feed_phase_d(fph[3]), .carriage_current_limit(cl), .feed_current_limit(fl),
    .head_timing_pulse(hts), .home_position_sense(hps), .paper_out_sense(pos_n),
    .power_fail_sense(power_fail_sense), .irq(irq));
  print_mech_model mech_u (.pclk(pclk), .ca(cph[0]), .cb(cph[1]), .cc(cph[2]), .cd(cph[3]),
    .paper_gone(paper_gone), .home_position_sense(hps), .head_timing_pulse(hts),
    .paper_out_sense(pos_n));
  initial forever #4 pclk = ~pclk;
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready, then idle cycles so outputs settle
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task idle_bit(input integer b);
    q = 32'hFFFFFFFF;
    while (q[b] !== 1'b0) apb(0, `OFF_STATUS, 0);
  endtask
  // host strobe is an active low pulse, byte taken at its rising edge
  task strobe(input [7:0] b);
    host_data_port <= b; repeat (2) @(posedge pclk);
    portc_bit2 <= 0; repeat (6) @(posedge pclk);
    portc_bit2 <= 1; repeat (6) @(posedge pclk);
  endtask
  // cycles between two phase changes of the selected motor
  task gap;
    p0 = mph; n = 0;
    while (mph === p0) @(posedge pclk);
    p0 = mph;
    while (mph === p0) begin n++; @(posedge pclk); end
    p1 = mph;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin #400000; fails++; wrap_up; end
  initial begin
    repeat (3) @(posedge pclk);
    chk("reset outputs", {cl, fl, portc_bit4, sol, cph}, 32'h6000);
    presetn <= 1;
    @(posedge pclk); idle_bit(4);
    chk("home reached", q[5], 1);
    chk("idle limit", cl, 1);
    strobe(8'hA5); chk("ready without mode", portc_bit1, 0);
    apb(1, `OFF_CTRL, 1); apb(1, `OFF_IRQ_MASK, 1);
    strobe(8'h5A); chk("ready", portc_bit1, 1);
    chk("rx irq", irq, 1);
    apb(0, `OFF_RX_DATA, 0); chk("rx byte", q[7:0], 8'h5A);
    apb(1, `OFF_IRQ_STAT, 1); chk("irq cleared", irq, 0);
    apb(0, 12'h0FC, 0); chk("unmapped err", err, 1); chk("unmapped data", q, 0);
    apb(1, `OFF_HEAD, 32'h1FF); chk("head on", {portc_bit4, sol}, 9'h1FF);
    repeat (12) @(posedge pclk); chk("head off", {portc_bit4, sol}, 0);
    apb(1, `OFF_CARR_CMD, 4); chk("moving limit", cl, 0);
    gap; chk("normal step", n, 20);
    chk("forward order", p1, {p0[2:0], p0[3]});
    idle_bit(2); apb(1, `OFF_CTRL, 3); apb(1, `OFF_CARR_CMD, 32'h10004);
    gap; chk("condensed step", n, 40);
    chk("reverse order", p1, {p0[0], p0[3:1]});
    idle_bit(2); use_feed = 1; apb(1, `OFF_FEED_CMD, 4);
    chk("feed limit", fl, 0);
    gap; chk("feed step", n, 40);
    idle_bit(3); paper_gone <= 1; power_fail_sense <= 1; repeat (4) @(posedge pclk);
    apb(1, `OFF_HEAD, 32'h1FF); chk("pfail head", {portc_bit4, sol}, 0);
    apb(0, `OFF_IRQ_STAT, 0); chk("pfail event", q[5], 1);
    apb(0, `OFF_STATUS, 0); chk("pfail paper status", q[7:6], 3);
    wrap_up;
  end
endmodule // printer_engine_controller_tb
